// File: verilog/indirect_pointer_access.sv
// Two data memory pointers with their alias locations, a working register and the data memory, behind APB.
// Assumes a well behaved APB master on pclk; the slave answers in the second access cycle.
//
// Functional notes
// - Post-decrement alias: use pointer, then decrement.
// - Pre-increment alias: increment pointer, then use it.
// - Alias locations store nothing; access memory instead.
// - Unimplemented locations read back as zero.
`timescale 1ns/1ps
module indirect_pointer_access
  import indirect_pkg::*;
#(
  parameter int ADDR_W = DM_ADDR_W
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB request.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer.
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Number of address bits above the data byte, filled by the offset's sign extension.
  localparam int SEXT_W = ADDR_W - DM_DATA_W;

  // Bus phase decode.
  wire access_phase;
  wire first_access;
  wire xfer_done;
  wire word_aligned;
  wire [11:0] word_idx;
  // Wait state flag: set in the first access cycle, so the second one completes.
  logic ack_reg;

  // Per-pointer storage and decode.
  logic [PTR_HIGH_W-1:0] ptr_high_reg [PTR_COUNT];
  logic [PTR_HIGH_W-1:0] ptr_high_next [PTR_COUNT];
  logic [DM_DATA_W-1:0] ptr_low_reg [PTR_COUNT];
  logic [DM_DATA_W-1:0] ptr_low_next [PTR_COUNT];
  wire [ADDR_W-1:0] ptr_val [PTR_COUNT];
  wire [ADDR_W-1:0] eff_addr [PTR_COUNT];
  wire [PTR_COUNT-1:0] sel_plain;
  wire [PTR_COUNT-1:0] sel_postinc;
  wire [PTR_COUNT-1:0] sel_postdec;
  wire [PTR_COUNT-1:0] sel_preinc;
  wire [PTR_COUNT-1:0] sel_offset;
  wire [PTR_COUNT-1:0] sel_high;
  wire [PTR_COUNT-1:0] sel_low;
  wire [PTR_COUNT-1:0] sel_alias;

  // Working register, which also supplies the signed offset.
  logic [DM_DATA_W-1:0] working_reg;
  wire sel_working;
  wire [ADDR_W-1:0] offset_sext;

  // Shared alias target and memory path.
  wire alias_any;
  wire [ADDR_W-1:0] target_addr;
  wire target_in_map;
  mem_req_t mem_req;
  wire [DM_DATA_W-1:0] mem_rdata;
  wire [DM_DATA_W-1:0] read_val;
  logic [31:0] prdata_reg;

  // An access completes in the second access cycle; this gives time to register read data.
  assign access_phase = psel & penable;
  assign first_access = access_phase & ~ack_reg;
  assign xfer_done = access_phase & ack_reg;
  assign word_aligned = (paddr[1:0] == 2'b00);
  assign word_idx = paddr[APB_ADDR_W-1:2];
  assign pready = xfer_done;
  assign pslverr = 1'b0;
  assign prdata = prdata_reg;

  // Wait state tracking; it drops again after completion so back to back transfers work.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= first_access;
    end
  end

  // Offset alias adds the working register as a signed byte.
  assign offset_sext = {{SEXT_W{working_reg[DM_DATA_W-1]}}, working_reg};
  assign sel_working = word_aligned & (word_idx == WORKING_REG_IDX);

  // Each pointer has the same set of locations; only the indices differ.
  genvar ch;
  generate
    for (ch = 0; ch < PTR_COUNT; ch++)
    begin : g_ptr
      // Location decode for this pointer.
      assign sel_plain[ch] = word_aligned & (word_idx == PLAIN_ALIAS_IDX[ch]);
      assign sel_postinc[ch] = word_aligned & (word_idx == POSTINC_ALIAS_IDX[ch]);
      assign sel_postdec[ch] = word_aligned & (word_idx == POSTDEC_ALIAS_IDX[ch]);
      assign sel_preinc[ch] = word_aligned & (word_idx == PREINC_ALIAS_IDX[ch]);
      assign sel_offset[ch] = word_aligned & (word_idx == OFFSET_ALIAS_IDX[ch]);
      assign sel_high[ch] = word_aligned & (word_idx == PTR_HIGH_IDX[ch]);
      assign sel_low[ch] = word_aligned & (word_idx == PTR_LOW_IDX[ch]);
      assign sel_alias[ch] = sel_plain[ch] | sel_postinc[ch] | sel_postdec[ch] | sel_preinc[ch]
                             | sel_offset[ch];

      // Full pointer value.
      assign ptr_val[ch] = {ptr_high_reg[ch], ptr_low_reg[ch]};

      // Address used by the alias: pre-increment sees the stepped value, offset adds W.
      assign eff_addr[ch] = sel_preinc[ch] ? ADDR_W'(ptr_val[ch] + PTR_STEP) :
                            sel_offset[ch] ? ADDR_W'(ptr_val[ch] + offset_sext) :
                            ptr_val[ch];

      // Next pointer value; it changes only at the completing edge of a transfer.
      always_comb
      begin
        ptr_high_next[ch] = ptr_high_reg[ch];
        ptr_low_next[ch] = ptr_low_reg[ch];
        if (xfer_done)
        begin
          if (sel_postinc[ch] | sel_preinc[ch])
          begin
            // Reads and writes alike step the pointer up.
            {ptr_high_next[ch], ptr_low_next[ch]} = ADDR_W'(ptr_val[ch] + PTR_STEP);
          end
          else if (sel_postdec[ch])
          begin
            // The old value was already used as address; now step down.
            {ptr_high_next[ch], ptr_low_next[ch]} = ADDR_W'(ptr_val[ch] - PTR_STEP);
          end
          else if (pwrite & sel_high[ch])
          begin
            // Only the implemented high bits are written.
            ptr_high_next[ch] = pwdata[PTR_HIGH_W-1:0];
          end
          else if (pwrite & sel_low[ch])
          begin
            ptr_low_next[ch] = pwdata[DM_DATA_W-1:0];
          end
          else
          begin
            // Plain and offset aliases leave the pointer alone.
            ptr_low_next[ch] = ptr_low_reg[ch];
          end
        end
      end

      // Pointer registers.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ptr_high_reg[ch] <= PTR_HIGH_RST;
          ptr_low_reg[ch] <= PTR_LOW_RST;
        end
        else
        begin
          ptr_high_reg[ch] <= ptr_high_next[ch];
          ptr_low_reg[ch] <= ptr_low_next[ch];
        end
      end

      // Checks that tie each alias to its pointer effect, and every alias but the plain one to its address.
      sequence s_alias_done(logic sel);
        xfer_done && sel;
      endsequence

      sequence s_alias_first(logic sel);
        first_access && sel;
      endsequence

      property p_postdec_addr;
        @(posedge pclk) disable iff (!presetn)
        s_alias_first(sel_postdec[ch]) |-> (target_addr == ptr_val[ch]) ##1 (target_addr == ptr_val[ch]);
      endproperty
      a_postdec_addr: assert property (p_postdec_addr) else $error("Post-decrement used a changed address.");

      property p_postdec_ptr;
        @(posedge pclk) disable iff (!presetn)
        s_alias_done(sel_postdec[ch]) |=> (ptr_val[ch] == ADDR_W'($past(ptr_val[ch]) - PTR_STEP));
      endproperty
      a_postdec_ptr: assert property (p_postdec_ptr) else $error("Post-decrement did not step the pointer down.");

      property p_preinc;
        @(posedge pclk) disable iff (!presetn)
        s_alias_done(sel_preinc[ch]) |-> (target_addr == ADDR_W'(ptr_val[ch] + PTR_STEP))
          ##1 (ptr_val[ch] == $past(target_addr));
      endproperty
      a_preinc: assert property (p_preinc) else $error("Pre-increment address and pointer disagree.");

      property p_plain_keeps;
        @(posedge pclk) disable iff (!presetn)
        s_alias_done(sel_plain[ch] | sel_offset[ch]) |=> $stable(ptr_val[ch]);
      endproperty
      a_plain_keeps: assert property (p_plain_keeps) else $error("Plain alias changed the pointer.");

      property p_postinc;
        @(posedge pclk) disable iff (!presetn)
        s_alias_first(sel_postinc[ch]) ##1 s_alias_done(sel_postinc[ch]) |->
          (target_addr == ptr_val[ch]) ##1 (ptr_val[ch] == ADDR_W'($past(ptr_val[ch]) + PTR_STEP));
      endproperty
      a_postinc: assert property (p_postinc) else $error("Post-increment did not use then step the pointer.");

      // The pointer may only move at the completing edge of a transfer.
      property p_ptr_hold;
        @(posedge pclk) disable iff (!presetn)
        !xfer_done |=> $stable(ptr_val[ch]);
      endproperty
      a_ptr_hold: assert property (p_ptr_hold) else $error("Pointer moved outside a completing edge.");

      // The offset alias reaches the pointer plus the signed working value.
      property p_offset_addr;
        @(posedge pclk) disable iff (!presetn)
        s_alias_done(sel_offset[ch]) |-> (target_addr == ADDR_W'(ptr_val[ch] + offset_sext));
      endproperty
      a_offset_addr: assert property (p_offset_addr) else $error("Offset alias used a wrong address.");
    end
  endgenerate

  // Only one pointer can be selected at a time, so a plain priority pick is enough.
  assign alias_any = |sel_alias;
  assign target_addr = sel_alias[0] ? eff_addr[0] : eff_addr[1];

  // Aliases that point back into this block's locations read zero and ignore writes.
  assign target_in_map = (target_addr[ADDR_W-1:4] == BLOCK_MAP_BASE[ADDR_W-1:4]);

  // Alias writes go to the data memory at the completing edge only; reads sample it in the first access cycle.
  assign mem_req.we = xfer_done & pwrite & alias_any & ~target_in_map;
  assign mem_req.addr = target_addr;
  assign mem_req.wdata = pwdata[DM_DATA_W-1:0];

  // The data memory behind the aliases.
  data_memory #(
    .ADDR_W(ADDR_W),
    .DATA_W(DM_DATA_W)
  ) u_data_memory (
    .pclk(pclk),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  // Read value mux; anything not decoded returns zero.
  assign read_val = (alias_any & ~target_in_map) ? mem_rdata :
                    sel_high[0] ? DM_DATA_W'(ptr_high_reg[0]) :
                    sel_high[1] ? DM_DATA_W'(ptr_high_reg[1]) :
                    sel_low[0] ? ptr_low_reg[0] :
                    sel_low[1] ? ptr_low_reg[1] :
                    sel_working ? working_reg :
                    '0;

  // Read data is captured in the first access cycle and held until the next read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= PRDATA_RST;
    end
    else if (first_access & ~pwrite)
    begin
      prdata_reg <= {24'h00_0000, read_val};
    end
  end

  // Working register write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      working_reg <= WORKING_RST;
    end
    else if (xfer_done & pwrite & sel_working)
    begin
      working_reg <= pwdata[DM_DATA_W-1:0];
    end
  end

  // Checks on the shared path.
  property p_alias_write;
    @(posedge pclk) disable iff (!presetn)
    (xfer_done && pwrite && alias_any && !target_in_map) |-> mem_req.we
      ##1 (u_data_memory.mem_array[$past(target_addr)] == $past(pwdata[DM_DATA_W-1:0]));
  endproperty
  a_alias_write: assert property (p_alias_write) else $error("Alias write did not reach memory.");

  property p_alias_read;
    @(posedge pclk) disable iff (!presetn)
    (first_access && !pwrite && alias_any && !target_in_map) |=> pready && (prdata[7:0] == $past(mem_rdata));
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("Alias read did not return memory data.");

  property p_unmapped_zero;
    @(posedge pclk) disable iff (!presetn)
    (first_access && !pwrite && !alias_any && !(|sel_high) && !(|sel_low) && !sel_working)
      |=> pready && (prdata == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unimplemented location read nonzero.");

  // An alias aimed back into this block's own locations reads zero.
  property p_inmap_read_zero;
    @(posedge pclk) disable iff (!presetn)
    (first_access && !pwrite && alias_any && target_in_map) |=> pready && (prdata == 32'h0000_0000);
  endproperty
  a_inmap_read_zero: assert property (p_inmap_read_zero) else $error("Alias into block range read nonzero.");

  // Only alias locations may write the data memory.
  property p_no_stray_write;
    @(posedge pclk) disable iff (!presetn)
    (mem_req.we) |-> (xfer_done && pwrite && alias_any && !target_in_map);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("Memory written outside an alias.");

  // The answer comes after exactly one wait state and stands for one cycle.
  property p_one_wait;
    @(posedge pclk) disable iff (!presetn)
    first_access |-> !pready ##1 (pready || !(psel && penable));
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("Answer did not follow one wait state.");

  // Completed transfers never flag an error and carry only a byte.
  property p_clean_answer;
    @(posedge pclk) disable iff (!presetn)
    pready |-> !pslverr && (prdata[31:DM_DATA_W] == '0);
  endproperty
  a_clean_answer: assert property (p_clean_answer) else $error("Answer carried an error or upper bits.");

endmodule // indirect_pointer_access

// File: verilog/indirect_pkg.sv
// Shared constants and types of the indirect pointer access block.
// Assumes an APB slave on a 32-bit bus, with each location taking one aligned word.
package indirect_pkg;

  // Data memory address width, data width and the implemented high pointer bits.
  localparam int DM_ADDR_W = 12;
  localparam int DM_DATA_W = 8;
  localparam int PTR_HIGH_W = 4;
  localparam int APB_ADDR_W = 14;
  localparam int PTR_COUNT = 2;

  // Location indices; the byte address on the bus is four times the index.
  localparam logic [11:0] WORKING_REG_IDX = 12'h0FE8;
  localparam logic [1:0][11:0] PLAIN_ALIAS_IDX = {12'h0FE7, 12'h0FEF};
  localparam logic [1:0][11:0] POSTINC_ALIAS_IDX = {12'h0FE6, 12'h0FEE};
  localparam logic [1:0][11:0] POSTDEC_ALIAS_IDX = {12'h0FE5, 12'h0FED};
  localparam logic [1:0][11:0] PREINC_ALIAS_IDX = {12'h0FE4, 12'h0FEC};
  localparam logic [1:0][11:0] OFFSET_ALIAS_IDX = {12'h0FE3, 12'h0FEB};
  localparam logic [1:0][11:0] PTR_HIGH_IDX = {12'h0FE2, 12'h0FEA};
  localparam logic [1:0][11:0] PTR_LOW_IDX = {12'h0FE1, 12'h0FE9};

  // Base of the 16-address data memory range that is treated as this block's own locations.
  localparam logic [11:0] BLOCK_MAP_BASE = 12'h0FE0;

  // Reset values and the pointer step.
  localparam logic [3:0] PTR_HIGH_RST = 4'h0;
  localparam logic [7:0] PTR_LOW_RST = 8'h00;
  localparam logic [7:0] WORKING_RST = 8'h00;
  localparam logic [11:0] PTR_STEP = 12'h0001;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

  // One request to the data memory.
  typedef struct packed {
    logic we;
    logic [DM_ADDR_W-1:0] addr;
    logic [DM_DATA_W-1:0] wdata;
  } mem_req_t;

endpackage

// File: verilog/data_memory.sv
// General purpose data memory reached through the indirect pointers.
// Assumes requests come from logic on the same clock; contents are not reset.
`timescale 1ns/1ps
module data_memory
  import indirect_pkg::*;
#(
  parameter int ADDR_W = DM_ADDR_W,
  parameter int DATA_W = DM_DATA_W
)
(
  // Clock.
  input wire logic pclk,
  // Request and read data.
  input mem_req_t req,
  output logic [DATA_W-1:0] rdata
);

  // Storage array; power-on contents are left undefined on purpose.
  logic [DATA_W-1:0] mem_array [2**ADDR_W];

  // Writes land on the rising edge when the request asks for one.
  always_ff @(posedge pclk)
  begin
    if (req.we)
    begin
      mem_array[req.addr] <= req.wdata;
    end
  end

  // Reads are asynchronous so the slave can sample the value in one cycle.
  assign rdata = mem_array[req.addr];

endmodule // data_memory

// File: verification/cpu_datapath_model.sv
// APB master that stands in for the CPU datapath reaching the pointer block.
// Assumes pclk comes from the bench; a transfer starts only when xfer is called.
`timescale 1ns/1ps
module cpu_datapath_model
  import indirect_pkg::*;
(
  // Clock and answer.
  input wire logic pclk,
  input wire logic pready,
  // Request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata
);
  // The bus is idle from time zero.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
  end

  // One transfer: setup, then access held until pready is sampled high.
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, data};
    @(posedge pclk);
    penable <= 1'b1;
    // Waits on the answer; the bench timeout cuts a hang short.
    do @(posedge pclk); while (pready !== 1'b1);
    // Released only after the completing edge; data inverted so stale values are not trusted.
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule // cpu_datapath_model

// File: verification/tb_indirect_pointer_access.sv
// Self-checking bench for the indirect pointer access block.
// Assumes the CPU model drives APB; read results are matched against a queue of notes.
`timescale 1ns/1ps
module tb_indirect_pointer_access
  import indirect_pkg::*;
;
  // Bus and control signals.
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [APB_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Counters and the expected read data queue.
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] exp_q[$];
  // Expected pointer and random data bytes.
  logic [11:0] ptr;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] c;

  indirect_pointer_access dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cpu_datapath_model u_cpu (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // Free running 25 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compares one value and counts the result.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Write and read tasks; a read notes its expected byte first.
  task automatic wr(input logic [11:0] idx, input logic [7:0] data);
    u_cpu.xfer(1'b1, idx, data);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h00_0000, exp});
    u_cpu.xfer(1'b0, idx, 8'h00);
  endtask

  // Takes the oldest note at each completed read and compares it.
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      // Every completed transfer must answer without an error.
      check("pslverr", 32'(pslverr), 32'h0000_0000);
      if (!pwrite)
      begin
        check("prdata", prdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxx_xxxx);
      end
    end
  end

  // Cuts a hang short.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    void'($urandom(11315));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, working register and an unimplemented location.
    for (int p = 0; p < PTR_COUNT; p++)
    begin
      rd(PTR_HIGH_IDX[p], 8'h00);
      rd(PTR_LOW_IDX[p], 8'h00);
    end
    rd(WORKING_REG_IDX, 8'h00);
    wr(12'h0FD0, 8'hA5);
    rd(12'h0FD0, 8'h00);
    // Every alias of both pointers, around a random base.
    for (int p = 0; p < PTR_COUNT; p++)
    begin
      ptr = 12'h100 + 12'(p * 12'h600) + 12'($urandom_range(0, 255));
      a = 8'($urandom());
      b = 8'($urandom());
      c = 8'($urandom());
      wr(PTR_HIGH_IDX[p], {4'h0, ptr[11:8]});
      wr(PTR_LOW_IDX[p], ptr[7:0]);
      wr(POSTINC_ALIAS_IDX[p], a);
      wr(POSTINC_ALIAS_IDX[p], b);
      wr(POSTDEC_ALIAS_IDX[p], c);
      rd(PTR_LOW_IDX[p], 8'(ptr + 12'h001));
      rd(PREINC_ALIAS_IDX[p], c);
      rd(PTR_LOW_IDX[p], 8'(ptr + 12'h002));
      rd(POSTDEC_ALIAS_IDX[p], c);
      rd(POSTDEC_ALIAS_IDX[p], b);
      rd(PLAIN_ALIAS_IDX[p], a);
      rd(PLAIN_ALIAS_IDX[p], a);
      rd(PTR_HIGH_IDX[p], {4'h0, ptr[11:8]});
      rd(PTR_LOW_IDX[p], ptr[7:0]);
      // Offset alias with a positive and a negative working value.
      wr(WORKING_REG_IDX, 8'h02);
      rd(WORKING_REG_IDX, 8'h02);
      rd(OFFSET_ALIAS_IDX[p], c);
      rd(POSTINC_ALIAS_IDX[p], a);
      wr(WORKING_REG_IDX, 8'hFF);
      rd(OFFSET_ALIAS_IDX[p], a);
    end
    // An alias aimed at the working register location reads zero and drops the write.
    wr(PTR_HIGH_IDX[0], 8'h0F);
    wr(PTR_LOW_IDX[0], 8'hE8);
    wr(PLAIN_ALIAS_IDX[0], 8'h5A);
    rd(PLAIN_ALIAS_IDX[0], 8'h00);
    rd(WORKING_REG_IDX, 8'hFF);
    repeat (4) @(posedge pclk);
    check("queue", 32'(exp_q.size()), 32'h0000_0000);
    stop_test();
  end
endmodule // tb_indirect_pointer_access
